// *** src/irig_params.svh ***
//////////////////////////////////////////////////////////////////////
// Purpose: Constants of the serial time-code generator
// Assumes: 100 MHz system clock
// Notes:   Widths are in tenths of an element slot
//////////////////////////////////////////////////////////////////////
`ifndef IRIG_PARAMS_SVH
`define IRIG_PARAMS_SVH
`define CLK_PERIOD_NS 10
// Slot spacing: 0.01 s for B, 1 s for H
`define SLOT_B_NS     10000000
`define SLOT_H_NS     1000000000
`define TENTHS        10
`define TENTH_B_CYC   ((`SLOT_B_NS / `TENTHS) / `CLK_PERIOD_NS)
`define TENTH_H_CYC   ((`SLOT_H_NS / `TENTHS) / `CLK_PERIOD_NS)
`define TENTH_LAST    4'h9
// 1 kHz carrier cut into sixteen phase steps
`define CARRIER_NS    1000000
`define AM_PHASES     16
`define AM_STEP_CYC   (`CARRIER_NS / `AM_PHASES / `CLK_PERIOD_NS)
// Element widths in tenths of a slot
`define W_MARK        4'h8
`define W_ONE         4'h5
`define W_ZERO        4'h2
// Frame geometry and control element slots
`define LAST_B        7'h63
`define LAST_H        7'h3b
`define CTRL_LOCK     7'h35
`define CTRL_ACC0     7'h37
`define CTRL_ACC3     7'h3a
`define SBS_FIRST     7'h50
`define TW_BITS       30
`endif

// *** src/irig_pkg.sv ***
//////////////////////////////////////////////////////////////////////
// Purpose: Types of the serial time-code generator
// Assumes: irig_params.svh on the include path
// Notes:   State of the generator is one packed struct
//////////////////////////////////////////////////////////////////////
package irig_pkg;
`include "irig_params.svh"
   typedef enum logic {MODE_B, MODE_H} mode_t;

   typedef struct packed {
      logic [23:0]          pre;
      logic [3:0]           tenth;
      logic [6:0]           idx;
      logic [3:0]           width;
      logic                 level;
      logic                 slot_start;
      logic                 on_time;
      logic                 tick;
      mode_t                mode;
      logic [`TW_BITS-1:0]  word;
      logic                 stale;
   } gen_state_t;
endpackage

// *** src/time_word_buffer.sv ***
//////////////////////////////////////////////////////////////////////
// Purpose: Two-entry buffer for time words
// Assumes: Source and sink on sys_clk_i
// Notes:   Head word comes straight from a register
//////////////////////////////////////////////////////////////////////
module time_word_buffer #(
   parameter int WIDTH = 30
) (
   input  wire logic             sys_clk_i,
   input  wire logic             rst_i,
   input  wire logic             s_valid_i,
   output logic                  s_ready_o,
   input  wire logic [WIDTH-1:0] s_data_i,
   output logic                  m_valid_o,
   input  wire logic             m_ready_i,
   output logic [WIDTH-1:0]      m_data_o
);
   typedef struct packed {
      logic [WIDTH-1:0] d0;
      logic [WIDTH-1:0] d1;
      logic [1:0]       cnt;
   } buf_state_t;

   buf_state_t q, d;
   logic push, pop;

   // Full refuses the source, so a stalled sink loses nothing
   assign s_ready_o = (q.cnt != 2'h2);
   assign m_valid_o = (q.cnt != 2'h0);
   assign m_data_o  = q.d0;
   assign push      = s_valid_i & s_ready_o;
   assign pop       = m_valid_o & m_ready_i;

   // Shift on pop, fill the first free entry on push
   always_comb begin
      d = q;
      if (pop && push) begin
         if (q.cnt == 2'h1) begin
            d.d0 = s_data_i;
         end else begin
            d.d0 = q.d1;
            d.d1 = s_data_i;
         end
      end else if (pop) begin
         d.d0  = q.d1;
         d.cnt = q.cnt - 2'h1;
      end else if (push) begin
         if (q.cnt == 2'h0) begin
            d.d0 = s_data_i;
         end else begin
            d.d1 = s_data_i;
         end
         d.cnt = q.cnt + 2'h1;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule

// *** src/am_carrier.sv ***
//////////////////////////////////////////////////////////////////////
// Purpose: 1 kHz amplitude-modulated form of the level-shift code
// Assumes: sync_i pulses at the start of every carrier period
// Notes:   Space level is about 0.31 of mark level
//////////////////////////////////////////////////////////////////////
module am_carrier #(
   parameter int STEP_CYC = `AM_STEP_CYC
) (
   input  wire logic        sys_clk_i,
   input  wire logic        rst_i,
   input  wire logic        sync_i,
   input  wire logic        mark_i,
   input  wire logic        enable_i,
   output logic signed [7:0] am_o
);
   typedef struct packed {
      logic [15:0]        step;
      logic [3:0]         phase;
      logic signed [7:0]  sample;
   } am_state_t;

   am_state_t q, d;
   logic signed [7:0] s;

   // Sixteen-point sine with peak of 100
   function automatic logic signed [7:0] sine(input logic [3:0] p);
      logic [7:0] m;
      m = 8'h00;
      case (p[2:0])
         3'h1, 3'h7: m = 8'h26;
         3'h2, 3'h6: m = 8'h47;
         3'h3, 3'h5: m = 8'h5c;
         3'h4:       m = 8'h64;
         default:    m = 8'h00;
      endcase
      sine = p[3] ? -$signed(m) : $signed(m);
   endfunction

   // Phase restarts on each slot tenth: rising zero crossing on edges
   always_comb begin
      d = q;
      s = sine(q.phase);
      if (sync_i) begin
         d.step  = '0;
         d.phase = '0;
      end else if (q.step == 16'(STEP_CYC - 1)) begin
         d.step  = '0;
         d.phase = (q.phase == 4'hf) ? q.phase : q.phase + 4'h1;
      end else begin
         d.step = q.step + 16'h0001;
      end
      if (!enable_i) begin
         d.sample = 8'h00;
      end else if (mark_i) begin
         d.sample = s;
      end else begin
         d.sample = (s >>> 2) + (s >>> 4);
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign am_o = q.sample;

   a_carrier_sync: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      sync_i |=> (q.phase == 4'h0) && (q.step == 16'h0000))
      else $error("carrier phase not restarted on slot edge");
   a_dc_only: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !enable_i |=> (am_o == 8'h00))
      else $error("carrier output while modulation disabled");
endmodule

// *** src/irig_time_code_generator.sv ***
//////////////////////////////////////////////////////////////////////
// Purpose: Serial time-code generator, B (100 el/s) and H (1 el/s)
// Assumes: epoch_i pulses on the on-time instant of each frame;
//          time word for the next frame is queued ahead of it
// Notes:   All inputs come from logic on sys_clk_i
// How it works
// - Frame sends BCD seconds (B only), minutes, hours, days, then control elements.
// - Straight binary seconds field is never sent; those slots carry zeros.
// - Every element rises on its slot edge; only the width varies.
// - Slots are 0.01 s apart in B and 1 s apart in H.
// - Frame opens with two back-to-back markers, each 0.008 s or 0.8 s high.
// - On-time instant is the rising edge of the second opening marker.
// - One frame per second in B, one per minute in H.
// - Position markers one slot before reference, then every tenth slot.
// - One is 0.005 s or 0.5 s high, zero 0.002 s or 0.2 s.
// - Each BCD digit goes out weights 1, 2, 4, 8, lowest first.
// - Carrier crosses zero upward on every element edge.
// - H output is level shift only, never modulated.
// - Control element 4 at reference plus 530 ms is one while locked.
// - Control elements 6 to 9 flag 1, 5, 50, 500 ms worst accuracy.
// - H frames carry no lock or accuracy elements.
// - Time word goes out as supplied; UTC 24-hour input makes it standard.
//////////////////////////////////////////////////////////////////////
module irig_time_code_generator
   import irig_pkg::*;
#(
   parameter int TENTH_B_CYC = `TENTH_B_CYC,
   parameter int TENTH_H_CYC = `TENTH_H_CYC,
   parameter int AM_STEP_CYC = `AM_STEP_CYC
) (
   input  wire logic        sys_clk_i,
   input  wire logic        rst_i,
   input  wire logic        epoch_i,
   input  wire logic        mode_h_i,
   input  wire logic        am_en_i,
   input  wire logic        locked_i,
   input  wire logic [3:0]  acc_i,
   input  wire logic        tw_valid_i,
   output logic             tw_ready_o,
   input  wire logic [6:0]  tw_sec_i,
   input  wire logic [6:0]  tw_min_i,
   input  wire logic [5:0]  tw_hour_i,
   input  wire logic [9:0]  tw_day_i,
   output logic             dcls_o,
   output logic signed [7:0] am_o,
   output logic             on_time_o,
   output logic             stale_o
);
   import irig_pkg::*;

   gen_state_t              q, d;
   logic                    buf_valid;
   logic                    buf_pop;
   logic [`TW_BITS-1:0]     buf_word;
   logic [`TW_BITS-1:0]     tw_word;
   logic [23:0]             pre_max;
   logic [6:0]              last_idx;
   logic                    new_slot;

   //////////////////////////////////////////////////////////////////////
   // Word slot of a time bit: {valid, bit index into the time word}.
   // B uses seconds..days; H drops seconds and moves each field down.
   function automatic logic [5:0] slot_bit(input mode_t m, input logic [6:0] i);
      logic [6:0] b;
      logic       v;
      b = 7'h00;
      v = 1'b1;
      if (m == MODE_B) begin
         if (i >= 7'd1 && i <= 7'd4) begin
            b = i - 7'd1;
         end else if (i >= 7'd6 && i <= 7'd8) begin
            b = i - 7'd2;
         end else if (i >= 7'd10 && i <= 7'd13) begin
            b = i - 7'd3;
         end else if (i >= 7'd15 && i <= 7'd17) begin
            b = i - 7'd4;
         end else if (i >= 7'd20 && i <= 7'd23) begin
            b = i - 7'd6;
         end else if (i >= 7'd25 && i <= 7'd26) begin
            b = i - 7'd7;
         end else if (i >= 7'd30 && i <= 7'd33) begin
            b = i - 7'd10;
         end else if (i >= 7'd35 && i <= 7'd38) begin
            b = i - 7'd11;
         end else if (i >= 7'd40 && i <= 7'd41) begin
            b = i - 7'd12;
         end else begin
            v = 1'b0;
         end
      end else begin
         if (i >= 7'd1 && i <= 7'd4) begin
            b = i + 7'd6;
         end else if (i >= 7'd6 && i <= 7'd8) begin
            b = i + 7'd5;
         end else if (i >= 7'd10 && i <= 7'd13) begin
            b = i + 7'd4;
         end else if (i >= 7'd15 && i <= 7'd16) begin
            b = i + 7'd3;
         end else if (i >= 7'd20 && i <= 7'd23) begin
            b = i;
         end else if (i >= 7'd25 && i <= 7'd28) begin
            b = i - 7'd1;
         end else if (i >= 7'd30 && i <= 7'd31) begin
            b = i - 7'd2;
         end else begin
            v = 1'b0;
         end
      end
      slot_bit = {v, b[4:0]};
   endfunction

   // Width in tenths of the element sent in slot i
   function automatic logic [3:0] elem_width(input mode_t m,
                                             input logic [6:0] i,
                                             input logic [`TW_BITS-1:0] w,
                                             input logic lk,
                                             input logic [3:0] acc);
      logic [5:0] sb;
      logic [6:0] a;
      sb = slot_bit(m, i);
      a  = i - `CTRL_ACC0;
      if (i == 7'h00 || (i % 7'd10) == 7'd9) begin
         elem_width = `W_MARK;
      end else if (sb[5]) begin
         elem_width = w[sb[4:0]] ? `W_ONE : `W_ZERO;
      end else if (m == MODE_B && i == `CTRL_LOCK) begin
         elem_width = lk ? `W_ONE : `W_ZERO;
      end else if (m == MODE_B && i >= `CTRL_ACC0 && i <= `CTRL_ACC3) begin
         elem_width = acc[a[1:0]] ? `W_ONE : `W_ZERO;
      end else begin
         elem_width = `W_ZERO;
      end
   endfunction

   //////////////////////////////////////////////////////////////////////
   // Time words wait here; the source stalls when both entries are full.
   // Passed on unchanged, so offset or 12-hour input goes out as is.
   assign tw_word = {tw_day_i, tw_hour_i, tw_min_i, tw_sec_i};

   time_word_buffer #(
      .WIDTH     (`TW_BITS)
   ) u_buf (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .s_valid_i (tw_valid_i),
      .s_ready_o (tw_ready_o),
      .s_data_i  (tw_word),
      .m_valid_o (buf_valid),
      .m_ready_i (buf_pop),
      .m_data_o  (buf_word)
   );

   // Slot timing follows the mode latched for the running frame
   assign pre_max  = (q.mode == MODE_H) ? 24'(TENTH_H_CYC - 1) : 24'(TENTH_B_CYC - 1);
   assign last_idx = (q.mode == MODE_H) ? `LAST_H : `LAST_B;
   assign new_slot = epoch_i || (q.pre == pre_max && q.tenth == `TENTH_LAST);
   // A word is taken only at the reference slot of a frame
   assign buf_pop  = new_slot && (epoch_i || q.idx == last_idx);

   //////////////////////////////////////////////////////////////////////
   // Slot and tenth counters; epoch realigns the reference slot at once
   always_comb begin
      d            = q;
      d.slot_start = 1'b0;
      d.on_time    = 1'b0;
      d.tick       = 1'b0;
      if (epoch_i) begin
         d.pre   = '0;
         d.tenth = '0;
         d.idx   = '0;
         d.tick  = 1'b1;
      end else if (q.pre == pre_max) begin
         d.pre  = '0;
         d.tick = 1'b1;
         if (q.tenth == `TENTH_LAST) begin
            d.tenth = '0;
            d.idx   = (q.idx == last_idx) ? 7'h00 : q.idx + 7'h01;
         end else begin
            d.tenth = q.tenth + 4'h1;
         end
      end else begin
         d.pre = q.pre + 24'h000001;
      end
      // Frame start: latch mode and the queued word for the new frame
      if (buf_pop) begin
         d.mode    = mode_h_i ? MODE_H : MODE_B;
         d.on_time = 1'b1;
         if (buf_valid) begin
            d.word  = buf_word;
            d.stale = 1'b0;
         end else begin
            d.stale = 1'b1; // Repeats the last word rather than stop
         end
      end
      if (new_slot) begin
         d.slot_start = 1'b1;
         d.width = elem_width(d.mode, d.idx, d.word, locked_i, acc_i);
      end
      // High from the slot edge until the width in tenths has passed
      d.level = (d.tenth < d.width);
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign dcls_o    = q.level;
   assign on_time_o = q.on_time;
   assign stale_o   = q.stale;

   //////////////////////////////////////////////////////////////////////
   // Modulated form only in B; carrier restarts each 1 ms tenth
   am_carrier #(
      .STEP_CYC  (AM_STEP_CYC)
   ) u_am (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .sync_i    (q.tick),
      .mark_i    (q.level),
      .enable_i  (am_en_i && q.mode == MODE_B),
      .am_o      (am_o)
   );

   //////////////////////////////////////////////////////////////////////
   // Checks on the generated element stream
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);

   a_lead_edge: assert property (
      q.slot_start |-> dcls_o && q.pre == 24'h0 && q.tenth == 4'h0)
      else $error("element not high on its slot edge");
   a_width_tenths: assert property (
      dcls_o == (q.tenth < q.width))
      else $error("element width not held to its tenths");
   a_slot_spacing: assert property (
      (q.pre == pre_max && q.tenth == `TENTH_LAST && !epoch_i) |=> q.slot_start)
      else $error("slot edge missed after ten tenths");
   a_ref_marker: assert property (
      on_time_o |-> q.idx == 7'h00 && q.width == `W_MARK && q.slot_start)
      else $error("on-time instant not on reference marker");
   a_pos_marker: assert property (
      q.slot_start && (q.idx % 7'd10) == 7'd9 |-> q.width == `W_MARK)
      else $error("position identifier not a marker");
   a_frame_wrap: assert property (
      q.slot_start && q.idx == last_idx && !epoch_i ##0
      (!epoch_i && !new_slot)[*2] |-> q.idx == last_idx)
      else $error("frame index moved inside a slot");
   a_sbs_zero: assert property (
      q.slot_start && q.idx >= `SBS_FIRST && (q.idx % 7'd10) != 7'd9
      |-> q.width == `W_ZERO)
      else $error("binary seconds field not zero");
   a_lock_elem: assert property (
      q.slot_start && q.mode == MODE_B && q.idx == `CTRL_LOCK
      |-> q.width == ($past(locked_i) ? `W_ONE : `W_ZERO))
      else $error("lock element does not follow lock state");
   a_acc_elem: assert property (
      q.slot_start && q.mode == MODE_B && q.idx == `CTRL_ACC3
      |-> q.width == ($past(acc_i[3]) ? `W_ONE : `W_ZERO))
      else $error("500 ms accuracy element wrong");
   a_h_no_ctrl: assert property (
      q.slot_start && q.mode == MODE_H && q.idx >= `CTRL_LOCK
      && (q.idx % 7'd10) != 7'd9 |-> q.width == `W_ZERO)
      else $error("control element sent in H frame");
   a_bcd_first: assert property (
      q.slot_start && q.mode == MODE_B && q.idx == 7'h01
      |-> q.width == (q.word[0] ? `W_ONE : `W_ZERO))
      else $error("units weight 1 not first");

   c_frame_b: cover property (on_time_o && q.mode == MODE_B);
   c_frame_h: cover property (on_time_o && q.mode == MODE_H);
   c_stalled: cover property (tw_valid_i && !tw_ready_o);
   c_stale:   cover property ($rose(stale_o));
endmodule

// *** sim/irig_reader.sv ***
//////////////////////////////////////////////////////////////////////
// Purpose: Behavioural time-code reader at the far end of the code line
// Assumes: Level-shift code at the B rate, tenth of a slot = TENTH cycles
// Notes:   Sorts pulses by width; drives the display flags of a remote
//////////////////////////////////////////////////////////////////////
module irig_reader #(
   parameter int TENTH = 20
) (
   input  wire logic sys_clk_i,
   input  wire logic rst_i,
   input  wire logic code_i,
   output logic      colon_flash_o,
   output logic      blink_o
);
   timeunit 1ns;
   timeprecision 1ps;

   int   width_q;
   int   idx_q;
   int   n;
   bit   one;
   bit   last_mark_q;
   logic code_q;

   // Judge each pulse at its falling edge; a marker after a marker opens a frame.
   // An idle reader treats the first marker as a reference, so it locks at once.
   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         width_q       <= 0;
         idx_q         <= 0;
         last_mark_q   <= 1'b1;
         code_q        <= 1'b0;
         colon_flash_o <= 1'b0;
         blink_o       <= 1'b0;
      end else begin
         code_q <= code_i;
         if (code_i === 1'b1) width_q <= width_q + 1;
         if (code_q === 1'b1 && code_i === 1'b0) begin
            one = (width_q >= 4 * TENTH) && (width_q < 7 * TENTH);
            n = (width_q >= 7 * TENTH && last_mark_q) ? 0 : idx_q + 1;
            idx_q       <= n;
            width_q     <= 0;
            last_mark_q <= (width_q >= 7 * TENTH);
            if (n == 57) colon_flash_o <= one;
            if (n == 58) blink_o <= one;
         end
      end
   end
endmodule

// *** sim/irig_time_code_generator_test.sv ***
//////////////////////////////////////////////////////////////////////
// Purpose: Self-checking bench for the serial time-code generator
// Assumes: Shortened tenth counts; reader model on the code line
// Notes:   Expected elements come from a queue of words held as integers
//////////////////////////////////////////////////////////////////////
module irig_time_code_generator_test;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int TB = 20;
   localparam int TH = 30;
   typedef struct {int s; int m; int h; int d; int lk; int acc;} word_t;

   logic              sys_clk_i = 1'b0;
   logic              rst_i = 1'b1;
   logic              epoch_i = 1'b0;
   logic              mode_h_i = 1'b0;
   logic              am_en_i = 1'b1;
   logic              locked_i = 1'b0;
   logic [3:0]        acc_i = 4'h0;
   logic              tw_valid_i = 1'b0;
   logic [6:0]        tw_sec_i = 7'h00;
   logic [6:0]        tw_min_i = 7'h00;
   logic [5:0]        tw_hour_i = 6'h00;
   logic [9:0]        tw_day_i = 10'h000;
   logic              tw_ready_o;
   logic              dcls_o;
   logic signed [7:0] am_o;
   logic              on_time_o;
   logic              stale_o;
   logic              flash;
   logic              blink;
   int                n_fail = 0;
   int                num_checks = 0;
   int                cyc = 0;
   int                nfr = 0;
   logic [31:0]       seed = 32'h283c7f64;
   word_t             q[$];
   word_t             cur;
   int                t0, rise, slot, nel, nmk, since, last_w, idx, ew;
   bit                hmode, started, prev_d, exp_stale;

   always #5 sys_clk_i = ~sys_clk_i;

   irig_time_code_generator #(.TENTH_B_CYC(TB), .TENTH_H_CYC(TH), .AM_STEP_CYC(1)) dut_u (
      .sys_clk_i(sys_clk_i), .rst_i(rst_i), .epoch_i(epoch_i), .mode_h_i(mode_h_i),
      .am_en_i(am_en_i), .locked_i(locked_i), .acc_i(acc_i), .tw_valid_i(tw_valid_i),
      .tw_ready_o(tw_ready_o), .tw_sec_i(tw_sec_i), .tw_min_i(tw_min_i),
      .tw_hour_i(tw_hour_i), .tw_day_i(tw_day_i), .dcls_o(dcls_o), .am_o(am_o),
      .on_time_o(on_time_o), .stale_o(stale_o));

   irig_reader #(.TENTH(TB)) reader_u (
      .sys_clk_i(sys_clk_i), .rst_i(rst_i), .code_i(dcls_o),
      .colon_flash_o(flash), .blink_o(blink));

   //////////////////////////////////////////////////////////////////////
   // Random source and the element model
   function automatic int rnd(input int n);
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return int'(seed[15:0]) % n;
   endfunction

   function automatic word_t rand_word();
      word_t w;
      w.s = rnd(60);
      w.m = rnd(60);
      w.h = rnd(24);
      w.d = rnd(366) + 1;
      w.lk = rnd(2);
      w.acc = rnd(16);
      return w;
   endfunction

   // Width in tenths; H drops seconds and control, moves minutes nine slots and the rest ten
   function automatic int exp_tenths(input bit h, input int i, input word_t w);
      int v[11];
      int st[11] = '{1, 6, 10, 15, 20, 25, 30, 35, 40, 53, 55};
      int n[11] = '{4, 3, 4, 3, 4, 2, 4, 4, 2, 1, 4};
      int off;
      v = '{w.s % 10, w.s / 10, w.m % 10, w.m / 10, w.h % 10, w.h / 10,
            w.d % 10, w.d / 10 % 10, w.d / 100, w.lk, w.acc};
      off = 0;
      if (i == 0 || i % 10 == 9) return 8;
      for (int k = h ? 2 : 0; k < (h ? 9 : 11); k++) begin
         // In H the minutes start one slot after the reference, the rest ten slots down
         if (h) off = (k < 4) ? 9 : 10;
         if (i >= st[k] - off && i < st[k] - off + n[k])
            return ((v[k] >> (i - st[k] + off)) & 1) ? 5 : 2;
      end
      return 2;
   endfunction

   //////////////////////////////////////////////////////////////////////
   // Comparisons and the closing report
   task automatic check_int(input string what, input int exp, input int got);
      num_checks++;
      if (exp !== got) begin
         n_fail++;
         $display("ERROR %s expected %0d seen %0d", what, exp, got);
      end
   endtask

   task automatic check_bit(input string what, input logic exp, input logic got);
      num_checks++;
      if (exp !== got) begin
         n_fail++;
         $display("ERROR %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic report_and_stop();
      $display("Checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Offer a word and hold it until the buffer takes it; valid stays up after
   task automatic push(input word_t w);
      tw_sec_i = 7'((w.s / 10) * 16 + w.s % 10);
      tw_min_i = 7'((w.m / 10) * 16 + w.m % 10);
      tw_hour_i = 6'((w.h / 10) * 16 + w.h % 10);
      tw_day_i = 10'((w.d / 100) * 256 + (w.d / 10 % 10) * 16 + w.d % 10);
      tw_valid_i = 1'b1;
      @(negedge sys_clk_i);
      while (tw_ready_o !== 1'b1) @(negedge sys_clk_i);
      @(posedge sys_clk_i);
      q.push_back(w);
      #1;
   endtask

   //////////////////////////////////////////////////////////////////////
   // Monitor: every element edge is compared with the model, just after the edge
   always @(posedge sys_clk_i) begin
      #1;
      cyc++;
      since++;
      if (cyc > 70000) begin
         n_fail++;
         report_and_stop();
      end
      if (on_time_o === 1'b1) begin
         if (started) begin
            check_int("elements per frame", hmode ? 60 : 100, nel);
            check_int("markers per frame", hmode ? 7 : 11, nmk);
            check_int("frame period", (hmode ? 60 : 100) * slot, cyc - t0);
            check_int("marker before reference", 8 * slot / 10, last_w);
            if (!hmode) check_bit("colon flash", cur.acc[2], flash);
            if (!hmode) check_bit("display blink", cur.acc[3], blink);
         end
         started = 1'b1;
         nfr++;
         t0 = cyc;
         nel = 0;
         nmk = 0;
         hmode = mode_h_i;
         slot = hmode ? 10 * TH : 10 * TB;
         exp_stale = (q.size() == 0);
         if (q.size() > 0) cur = q.pop_front();
         locked_i = cur.lk[0];
         acc_i = cur.acc[3:0];
      end
      if (started && dcls_o === 1'b1 && !prev_d) begin
         rise = cyc;
         since = 0;
         nel++;
         check_int("element phase", 0, (cyc - t0) % slot);
      end
      if (started && dcls_o === 1'b0 && prev_d) begin
         idx = (rise - t0) / slot;
         ew = exp_tenths(hmode, idx, cur) * slot / 10;
         last_w = cyc - rise;
         if (ew == 8 * slot / 10) nmk++;
         if (ew == 8 * slot / 10) check_int("marker width", ew, last_w);
         else if (!hmode && idx > 50) check_int("control width", ew, last_w);
         else check_int("data width", ew, last_w);
      end
      if (started && since == 3 && nel == 1) check_bit("stale flag", exp_stale, stale_o);
      if (started && since == 4 && hmode) check_bit("carrier off", 1'b1, am_o === 8'sh00);
      if (started && since == 4 && !hmode) check_bit("carrier rising", 1'b1, am_o > 0);
      if (started && since == 12 && !hmode) check_bit("carrier falling", 1'b1, am_o < 0);
      prev_d = (dcls_o === 1'b1);
   end

   //////////////////////////////////////////////////////////////////////
   // Main sequence: fill the buffer, epoch while a word waits, then B, B, H
   initial begin
      repeat (4) @(posedge sys_clk_i);
      #1;
      check_bit("code idle in reset", 1'b0, dcls_o);
      check_bit("ready in reset", 1'b1, tw_ready_o);
      rst_i = 1'b0;
      push(rand_word());
      push(rand_word());
      check_bit("buffer full", 1'b0, tw_ready_o);
      fork
         push(rand_word());
         begin
            repeat (3) @(posedge sys_clk_i);
            #1;
            epoch_i = 1'b1;
            @(posedge sys_clk_i);
            #1;
            epoch_i = 1'b0;
            check_bit("on time after epoch", 1'b1, on_time_o);
            check_bit("reference marker rise", 1'b1, dcls_o);
         end
      join
      tw_valid_i = 1'b0;
      wait (nfr == 2);
      repeat (50) @(posedge sys_clk_i);
      #1;
      mode_h_i = 1'b1;
      wait (nfr == 4);
      repeat (10) @(posedge sys_clk_i);
      report_and_stop();
   end
endmodule
